// ### core/sar_conversion_sequencer.sv
// Purpose: control of a 10-bit successive approximation converter
// Assumes: all inputs synchronous to ref_clk (20 MHz)
// Notes: converter clock is an enable pulse from the prescaler
//
// Notes on behaviour
// R1: 10-bit result, right or left aligned
// R2: low byte read locks until high read
// R3: done flag set even when discarded
// R4: start bit begins conversion, self clears
// R5: channel change waits for conversion end
// R6: trigger edge resets prescaler, starts conversion
// R7: edges during conversion ignored, no relevel
// R8: source flag cleared by software between triggers
// R9: done flag trigger converts continuously
// R10: start works under auto, reads busy
// R11: prescaler runs only while enabled
// R12: software start waits next converter edge
// R13: 13 cycles, first after enable 25
// R14: sample at 1.5, first at 14.5
// R15: completion stores result, flags, clears start
// R16: selections effective only when enabled
// R17: six-bit select, 100010 temperature sensor
// R18: bit zero picks gain, single-ended bypass
// R19: two-bit reference select
// R20: buffer disable forces port bit zero
// R21: triggered sample two cycles after edge
// R22: selection locked during conversion, tracks end
// R23: free running keeps start bit high
// R24: field encodings kept as local choices
//
// Chosen here: strobed register access.
`include "sar_seq_map.svh"

module sar_conversion_sequencer
  import sar_seq_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // register port
  input wire reg_bus_t bus,
  output logic [7:0] rd_data,
  // analog core side
  input wire logic [9:0] sar_result,
  output analog_ctrl_t analog,
  // trigger sources and port pins
  input wire logic [7:0] trig_in,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_value,
  output logic [7:0] buf_disable
);

  ////////////////////////////////////////////////////////////////
  // state and derived terms

  seq_regs_t s; // registered state
  seq_regs_t next_s; // next state
  logic [2:0] div_exp; // prescaler power of two
  logic [7:0] div_last; // last prescaler count
  logic tick; // converter clock rising edge
  logic half; // converter clock falling edge
  logic free_sel; // own done flag as trigger
  logic trig_lvl; // selected trigger level
  logic trig_edge; // its rising edge
  logic trig_go; // start by trigger
  logic [4:0] len_last; // last cycle of an untriggered conversion
  logic [4:0] last_c; // cycle where tracking resumes
  logic samp_evt; // sample instant
  logic done_evt; // completion instant
  logic track; // selection follows register
  logic diff; // differential channel

  // R24 division select as power of two, zero taken as two
  assign div_exp = (s.div_sel == 3'h0) ? 3'h1 : s.div_sel;
  assign div_last = 8'((8'h01 << div_exp) - 8'h01);
  // R11 converter clock edges from the prescaler
  // half is the falling edge; with divide by two it lands on count zero
  assign tick = s.enable && (s.presc == div_last);
  assign half = s.enable && (s.presc == (div_last >> 1));

  // R24 trigger index picks a source, one code means free run
  assign free_sel = (s.trig_sel == `FREE_RUN_SEL);
  assign trig_lvl = trig_in[s.trig_sel];
  // R8 a source flag left high gives no new edge until cleared
  assign trig_edge = trig_lvl && !s.trig_prev;
  // R6 edge only in idle or armed
  // R7 edges during a conversion fall through here
  assign trig_go = s.enable && s.auto_en && !free_sel &&
                   trig_edge && (s.state != ST_CONV);

  // R13 first conversion longer
  assign len_last = s.first ? `FIRST_LAST : `NORM_LAST;
  assign last_c = s.trig_conv ? `TRIG_LAST : len_last;

  // R14 normal and first sample on the falling edge
  // R21 triggered sample two converter cycles after edge
  assign samp_evt = (s.state == ST_CONV) && (s.trig_conv ?
    (tick && s.cyc == `TRIG_SAMPLE) :
    (half && s.cyc == (s.first ? `FIRST_SAMPLE : `NORM_SAMPLE)));

  // R13 completion at end of the last cycle, triggered ones on the falling edge of cycle 13
  assign done_evt = (s.state == ST_CONV) && (s.trig_conv ?
    (half && s.cyc == `TRIG_DONE) : (tick && s.cyc == len_last));

  // R22 tracking outside a conversion or from cycle last_c on
  // a write landing mid conversion waits in chan_reg until this opens
  assign track = (s.state != ST_CONV) || (s.cyc >= last_c);

  // R17 R18 single-ended codes below eight, sensor bypasses too
  assign diff = (s.chan_act > `LAST_SINGLE) &&
                (s.chan_act != `TEMP_CHAN);

  ////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_s = s;
    next_s.analog.sample_hold = 1'b0;
    // read data stands one cycle only, zero otherwise
    next_s.rd_data = `BYTE_ZERO;
    next_s.trig_prev = trig_lvl;
    // R20 masked port bits
    next_s.pin_value = pin_in & ~s.buf_dis;

    // R11 prescaler held clear while disabled
    if (!s.enable || trig_go) begin
      // R6 trigger realigns converter clock
      next_s.presc = 8'h00;
    end else if (tick) begin
      next_s.presc = 8'h00;
    end else begin
      next_s.presc = 8'(s.presc + 8'h01);
    end

    // register writes
    if (bus.wr) begin
      if (bus.addr == `CTRL_A_ADDR) begin
        next_s.enable = bus.wdata[`EN_BIT];
        next_s.auto_en = bus.wdata[`AUTO_BIT];
        next_s.div_sel = bus.wdata[`DIV_HI:0];
        // flag cleared by writing one
        if (bus.wdata[`DONE_BIT]) begin
          next_s.done_flag = 1'b0;
        end
        // R4 R10 start accepted whenever idle, enable may come in the same write
        if (bus.wdata[`START_BIT] && bus.wdata[`EN_BIT] && s.state == ST_IDLE) begin
          next_s.state = ST_ARMED;
        end
      end else if (bus.addr == `CTRL_B_ADDR) begin
        next_s.left_align = bus.wdata[`ALIGN_BIT];
        next_s.trig_sel = bus.wdata[`TRIG_HI:0];
      end else if (bus.addr == `CHAN_REF_ADDR) begin
        // R19 reference and R17 input held in buffer
        next_s.ref_reg = bus.wdata[`REF_HI:`REF_LO];
        next_s.chan_reg = bus.wdata[`CHAN_HI:0];
      end else if (bus.addr == `PIN_BUF_DIS_ADDR) begin
        next_s.buf_dis = bus.wdata;
      end
    end

    // register reads, data valid next cycle
    if (bus.rd) begin
      if (bus.addr == `CTRL_A_ADDR) begin
        // R10 start bit shows any running conversion
        next_s.rd_data = {s.enable, s.state != ST_IDLE, s.auto_en,
                          s.done_flag, 1'b0, s.div_sel};
      end else if (bus.addr == `CTRL_B_ADDR) begin
        next_s.rd_data = {3'h0, s.left_align, 1'b0, s.trig_sel};
      end else if (bus.addr == `CHAN_REF_ADDR) begin
        next_s.rd_data = {s.ref_reg, s.chan_reg};
      end else if (bus.addr == `PIN_BUF_DIS_ADDR) begin
        next_s.rd_data = s.buf_dis;
      end else if (bus.addr == `RES_LOW_ADDR) begin
        // R1 low byte per alignment
        next_s.rd_data = s.left_align ? {s.result[1:0], 6'h00} :
                                        s.result[7:0];
        // R2 low read locks the pair
        next_s.rd_lock = 1'b1;
      end else if (bus.addr == `RES_HIGH_ADDR) begin
        next_s.rd_data = s.left_align ? s.result[9:2] :
                                        {6'h00, s.result[9:8]};
        // R2 high read releases
        next_s.rd_lock = 1'b0;
      end
    end

    // sequencing
    case (s.state)
      ST_ARMED: begin
        // R12 software start begins on converter edge
        if (tick) begin
          next_s.state = ST_CONV;
          next_s.cyc = 5'h00;
          next_s.trig_conv = 1'b0;
        end
      end
      ST_CONV: begin
        if (tick) begin
          next_s.cyc = 5'(s.cyc + 5'h01);
        end
        // R14 hold pulse to core
        if (samp_evt) begin
          next_s.analog.sample_hold = 1'b1;
        end
        if (done_evt) begin
          // R2 discard while locked
          if (!s.rd_lock) begin
            // R15 result stored at completion
            next_s.result = sar_result;
          end
          // R3 flag regardless of lock
          next_s.done_flag = 1'b1;
          next_s.first = 1'b0;
          next_s.cyc = 5'h00;
          next_s.trig_conv = 1'b0;
          // R9 R23 restart at once, start bit stays high
          if (s.auto_en && free_sel) begin
            next_s.state = ST_CONV;
          end else begin
            // R15 single mode clears start
            next_s.state = ST_IDLE;
          end
        end
      end
      default: begin
        // idle: nothing to do
      end
    endcase

    // R6 trigger start overrides a pending software start
    if (trig_go) begin
      next_s.state = ST_CONV;
      next_s.cyc = 5'h00;
      next_s.trig_conv = 1'b1;
    end

    // disable aborts, next conversion is the long one
    if (!next_s.enable) begin
      // R11 prescaler cleared in the very cycle enable drops
      next_s.presc = 8'h00;
      next_s.state = ST_IDLE;
      next_s.first = 1'b1;
      next_s.trig_conv = 1'b0;
    end

    // R5 R22 selection follows buffer only when safe
    if (track) begin
      next_s.chan_act = s.chan_reg;
      next_s.ref_act = s.ref_reg;
    end

    // R16 analog controls quiet while disabled, except gain_bypass
    next_s.analog.enable = s.enable;
    next_s.analog.channel = s.enable ? s.chan_act : `CHAN_ZERO;
    next_s.analog.reference = s.enable ? s.ref_act : `REF_ZERO;
    // R18 gain from bit zero on differential pairs
    next_s.analog.gain_20x = s.enable && diff && s.chan_act[0];
    next_s.analog.gain_bypass = !diff;
  end

  ////////////////////////////////////////////////////////////////
  // state register

  // whole state in one flop bank, constants on reset
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s <= '0;
      s.state <= ST_IDLE;
      s.first <= 1'b1;
      s.analog.gain_bypass <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flops
  assign rd_data = s.rd_data;
  assign analog = s.analog;
  assign pin_value = s.pin_value;
  assign buf_disable = s.buf_dis;

  ////////////////////////////////////////////////////////////////
  // checks

  // checks look at the registered outputs where they can, so a broken
  // decode of the event terms shows up instead of agreeing with itself;
  // all of them live in the single ref_clk domain
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  chk_presc_held: assert property ( // R11
    !s.enable |-> s.presc == 8'h00)
    else $error("prescaler runs while disabled");

  chk_start_edge: assert property ( // R12
    s.state == ST_ARMED && !tick |=> s.state != ST_CONV || s.trig_conv)
    else $error("software start left converter edge");

  chk_conv_len: assert property ( // R13
    s.state == ST_CONV && !s.trig_conv |-> s.cyc <= (s.first ? `FIRST_LAST : `NORM_LAST))
    else $error("conversion length wrong");

  chk_sample_pos: assert property ( // R14
    analog.sample_hold && !$past(s.trig_conv) |-> $past(s.state) == ST_CONV &&
    $past(half) && $past(s.cyc) == ($past(s.first) ? `FIRST_SAMPLE : `NORM_SAMPLE))
    else $error("sample instant wrong");

  chk_hold_single: assert property ( // R14
    analog.sample_hold |=> !analog.sample_hold)
    else $error("sample pulse too long");

  chk_trig_start: assert property ( // R6
    trig_go && !bus.wr |=> s.state == ST_CONV && s.trig_conv && s.presc == 8'h00)
    else $error("trigger did not start conversion");

  chk_trig_ignore: assert property ( // R7
    s.state == ST_CONV && !done_evt && !bus.wr
    |=> s.state == ST_CONV && s.trig_conv == $past(s.trig_conv))
    else $error("conversion restarted mid run");

  chk_free_start: assert property ( // R9
    s.state == ST_IDLE && free_sel && !bus.wr |=> s.state == ST_IDLE)
    else $error("free run started without start bit");

  chk_lock_set: assert property ( // R2
    bus.rd && bus.addr == `RES_LOW_ADDR |=> s.rd_lock)
    else $error("low byte read did not lock");

  chk_sel_off: assert property ( // R16
    !s.enable |=> analog.channel == `CHAN_ZERO && analog.reference == `REF_ZERO)
    else $error("selection driven while disabled");

  chk_gain_pick: assert property ( // R18
    s.enable && s.chan_act > `LAST_SINGLE && s.chan_act != `TEMP_CHAN
    |=> analog.gain_20x == $past(s.chan_act[0]))
    else $error("differential gain wrong");

  chk_temp_bypass: assert property ( // R17
    s.chan_act == `TEMP_CHAN || s.chan_act <= `LAST_SINGLE |=> analog.gain_bypass)
    else $error("gain stage not bypassed");

  chk_lock_keep: assert property ( // R2
    done_evt && s.rd_lock |=> $stable(s.result))
    else $error("locked result overwritten");

  chk_flag_set: assert property ( // R3
    done_evt |=> s.done_flag)
    else $error("done flag missing");

  chk_single_end: assert property ( // R15
    done_evt && !(s.auto_en && free_sel) && s.enable && !trig_go
    |=> s.state == ST_IDLE)
    else $error("start bit not cleared");

  chk_free_run: assert property ( // R23
    done_evt && s.auto_en && free_sel && s.enable && !bus.wr
    |=> s.state == ST_CONV ##1 s.state == ST_CONV)
    else $error("free run stopped");

  chk_chan_hold: assert property ( // R5
    s.state == ST_CONV && s.cyc < last_c |=> $stable(s.chan_act))
    else $error("channel changed mid conversion");

  chk_busy_read: assert property ( // R10
    bus.rd && bus.addr == `CTRL_A_ADDR && s.state == ST_CONV
    |=> rd_data[`START_BIT])
    else $error("start bit reads low while busy");

  chk_pin_mask: assert property ( // R20
    1'b1 |=> (pin_value & $past(s.buf_dis)) == 8'h00)
    else $error("disabled pin reads high");

  cov_first: cover property (done_evt && s.first);
  cov_free: cover property (done_evt && s.auto_en && free_sel);
  cov_discard: cover property (done_evt && s.rd_lock);
  cov_trig: cover property (trig_go);
  cov_relevel: cover property (done_evt && trig_lvl && s.trig_conv);

endmodule : sar_conversion_sequencer

// ### core/sar_seq_map.svh
// Purpose: register offsets, field positions and counts
// Assumes: byte wide register port, 6-bit address
// Notes: definitions only
`ifndef SAR_SEQ_MAP_SVH
`define SAR_SEQ_MAP_SVH

// register offsets
`define PIN_BUF_DIS_ADDR 6'h01
`define CTRL_B_ADDR 6'h03
`define RES_LOW_ADDR 6'h04
`define RES_HIGH_ADDR 6'h05
`define CTRL_A_ADDR 6'h06
`define CHAN_REF_ADDR 6'h07

// converter_control_a fields
`define EN_BIT 7
`define START_BIT 6
`define AUTO_BIT 5
`define DONE_BIT 4
`define DIV_HI 2
// converter_control_b fields
`define ALIGN_BIT 4
`define TRIG_HI 2
// channel_reference_reg fields
`define REF_HI 7
`define REF_LO 6
`define CHAN_HI 5

// reset values
`define BYTE_ZERO 8'h00
`define CHAN_ZERO 6'h00
`define REF_ZERO 2'h0

// channel codes
`define TEMP_CHAN 6'h22
`define LAST_SINGLE 6'h07
// trigger code meaning "own completion flag"
`define FREE_RUN_SEL 3'h0

// conversion timing, converter clock cycles
`define NORM_LAST 5'h0C
`define FIRST_LAST 5'h18
`define NORM_SAMPLE 5'h01
`define FIRST_SAMPLE 5'h0E
`define TRIG_SAMPLE 5'h01
`define TRIG_DONE 5'h0D
`define TRIG_LAST 5'h0C

`endif

// ### core/sar_seq_pkg.sv
// Purpose: types for the conversion sequencer
// Assumes: map header gives the numbers
// Notes: whole state lives in one packed struct
package sar_seq_pkg;

  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_CONV = 2'b10
  } seq_state_t;

  // register port request
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_bus_t;

  // controls toward the analog core
  typedef struct packed {
    logic enable;
    logic [5:0] channel;
    logic [1:0] reference;
    logic gain_20x;
    logic gain_bypass;
    logic sample_hold;
  } analog_ctrl_t;

  // complete sequencer state
  typedef struct packed {
    seq_state_t state;
    logic [7:0] presc;
    logic [4:0] cyc;
    logic first;
    logic trig_conv;
    logic done_flag;
    logic enable;
    logic auto_en;
    logic [2:0] div_sel;
    logic [2:0] trig_sel;
    logic left_align;
    logic [5:0] chan_reg;
    logic [1:0] ref_reg;
    logic [5:0] chan_act;
    logic [1:0] ref_act;
    logic [9:0] result;
    logic rd_lock;
    logic [7:0] buf_dis;
    logic [7:0] rd_data;
    logic trig_prev;
    logic [7:0] pin_value;
    analog_ctrl_t analog;
  } seq_regs_t;

endpackage : sar_seq_pkg

// ### test/analog_core_stub.sv
// Purpose: behavioural stand-in for the mux, gain stage and converter core
// Assumes: result is a code built from the channel held at the sample pulse
// Notes: a powered-down core does not keep showing its last code
module analog_core_stub
  import sar_seq_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // controls and result
  input wire analog_ctrl_t analog,
  output logic [9:0] sar_result
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] held; // code captured at the sample instant

  ////////////////////////////////////////////////////////////////
  // capture on the sample pulse, code tells the bench the channel
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      held <= 10'h000;
    end else if (analog.sample_hold) begin
      held <= {analog.channel, 4'hB};
    end
  end

  // unpowered core shows the inverse, so a stale read cannot pass
  assign sar_result = analog.enable ? held : ~held;
endmodule : analog_core_stub

// ### test/sar_conversion_sequencer_test.sv
// Purpose: register level tests of the conversion sequencer
// Assumes: divider code 0, so one converter cycle is two ref_clk cycles
// Notes: done is found by polling, so timing windows allow poll slack
`include "sar_seq_map.svh"
module sar_conversion_sequencer_test
  import sar_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  reg_bus_t bus = '0;
  logic [7:0] rd_data, pin_value, buf_disable;
  logic [7:0] trig_in = 8'h00;
  logic [7:0] pin_in = 8'hFF;
  logic [9:0] sar_result;
  analog_ctrl_t analog;
  int err_count = 0;
  int total_checks = 0;
  int sh_cnt = 0; // sample pulses seen
  int n; // clocks until done
  logic [7:0] d;

  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (analog.sample_hold === 1'b1) sh_cnt++;

  sar_conversion_sequencer uut (.ref_clk(ref_clk), .reset(reset), .bus(bus),
    .rd_data(rd_data), .sar_result(sar_result), .analog(analog), .trig_in(trig_in),
    .pin_in(pin_in), .pin_value(pin_value), .buf_disable(buf_disable));
  analog_core_stub core (.ref_clk(ref_clk), .reset(reset), .analog(analog),
    .sar_result(sar_result));

  ////////////////////////////////////////////////////////////////
  // bus tasks and compares
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1 v = rd_data;
  endtask : rd
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    total_checks++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk
  task automatic rdchk(input logic [5:0] a, input logic [7:0] e, input string nm);
    logic [7:0] v;
    rd(a, v);
    chk(nm, {2'b00, e}, {2'b00, v});
  endtask : rdchk
  // poll the done flag, bounded; n counts ref_clk cycles
  task automatic wait_done(input int lo, input int hi, input string nm);
    logic [7:0] v;
    n = 0;
    v = 8'h00;
    while (!v[`DONE_BIT] && n < 400) begin
      rd(`CTRL_A_ADDR, v);
      n += 2;
    end
    chk(nm, 10'h001, {9'h000, (n >= lo && n <= hi)});
  endtask : wait_done
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////
  // watchdog, tests need well under 3000 cycles
  initial begin
    #(50 * 20000);
    err_count++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    // buffer disable register and pin masking
    rdchk(`PIN_BUF_DIS_ADDR, 8'h00, "bufdis reset");
    wr(`PIN_BUF_DIS_ADDR, 8'hA5);
    rdchk(`PIN_BUF_DIS_ADDR, 8'hA5, "bufdis rw");
    rdchk(6'h3F, 8'h00, "unmapped");
    chk("pin_value", 10'h05A, {2'b00, pin_value});
    chk("buf_disable", 10'h0A5, {2'b00, buf_disable});
    $display("test registers done");
    // first conversion, right aligned, channel 5
    wr(`CHAN_REF_ADDR, 8'h45);
    wr(`CTRL_A_ADDR, 8'hC0);
    rdchk(`CTRL_A_ADDR, 8'hC0, "busy");
    chk("reference", 10'h001, {8'h00, analog.reference});
    wait_done(50, 56, "first time");
    rdchk(`CTRL_A_ADDR, 8'h90, "start cleared");
    rdchk(`RES_LOW_ADDR, 8'h5B, "low right");
    rdchk(`RES_HIGH_ADDR, 8'h00, "high right");
    // normal conversion, channel change mid-run takes effect after
    wr(`CTRL_A_ADDR, 8'hD0);
    wr(`CHAN_REF_ADDR, 8'h62);
    repeat (4) @(negedge ref_clk);
    chk("locked chan", 10'h005, {4'h0, analog.channel});
    wait_done(22, 26, "normal time");
    rdchk(`RES_LOW_ADDR, 8'h5B, "old channel");
    rdchk(`RES_HIGH_ADDR, 8'h00, "old high");
    chk("temp bypass", 10'h001, {9'h000, analog.gain_bypass});
    $display("test single done");
    // left aligned on temperature channel, then lock
    wr(`CTRL_B_ADDR, 8'h10);
    wr(`CTRL_A_ADDR, 8'hD0);
    wait_done(26, 32, "left time");
    rdchk(`RES_LOW_ADDR, 8'hC0, "low left");
    wr(`CHAN_REF_ADDR, 8'h49);
    wr(`CTRL_A_ADDR, 8'hD0);
    wait_done(26, 32, "flag while locked");
    chk("gain 20x", 10'h001, {9'h000, analog.gain_20x});
    rdchk(`RES_HIGH_ADDR, 8'h8A, "discarded");
    wr(`CTRL_A_ADDR, 8'hD0);
    wait_done(26, 32, "unlocked time");
    rdchk(`RES_LOW_ADDR, 8'hC0, "new low");
    rdchk(`RES_HIGH_ADDR, 8'h26, "new high");
    $display("test lock done");
    // disable drops selections
    wr(`CTRL_A_ADDR, 8'h10);
    repeat (2) @(negedge ref_clk);
    chk("off enable", 10'h000, {9'h000, analog.enable});
    chk("off chan", 10'h000, {4'h0, analog.channel});
    // auto trigger on source 1
    wr(`CTRL_B_ADDR, 8'h01);
    wr(`CTRL_A_ADDR, 8'hB0);
    repeat (6) @(posedge ref_clk);
    trig_in <= 8'h02;
    rdchk(`CTRL_A_ADDR, 8'hE0, "trig busy");
    wait_done(24, 30, "trig time");
    wr(`CTRL_A_ADDR, 8'hB0);
    repeat (80) @(posedge ref_clk);
    rdchk(`CTRL_A_ADDR, 8'hA0, "no relevel");
    // source drops and rises again before next conversion
    @(posedge ref_clk);
    trig_in <= 8'h00;
    repeat (2) @(posedge ref_clk);
    trig_in <= 8'h02;
    wait_done(24, 32, "retrigger");
    $display("test trigger done");
    // free running from own completion flag
    @(posedge ref_clk);
    trig_in <= 8'h00;
    wr(`CTRL_B_ADDR, 8'h00);
    wr(`CTRL_A_ADDR, 8'hF0);
    wait_done(24, 32, "free first");
    sh_cnt = 0;
    repeat (100) @(posedge ref_clk);
    chk("free pulses", 10'h001, {9'h000, sh_cnt >= 3});
    rdchk(`CTRL_A_ADDR, 8'hF0, "free busy");
    $display("test free run done");
    report_and_stop();
  end
endmodule : sar_conversion_sequencer_test
